// >>> hw/twi_target.sv
// Purpose: Two-wire target for a clock register file and byte memory
// Assumes: Link lines sampled through two flops at 40 MHz
// Notes:   Received data bytes pass a FIFO before storage
// How it works
// - Controller makes all clocks, START, STOP
// - STOP or repeated START ends transfer
// - Bytes shift most significant bit first
// - START begins, STOP ends, sequencing resets
// - First byte is address, matched in hardware
// - Clock registers answer only 1101000
// - Small memory answers any 1010xxx
// - Large memory answers only 1010000
// - Eighth bit low writes, high reads
// - Matching address acknowledged on ninth clock
// - Every received byte acknowledged
// - Word address loads the register pointer
// - Large memory takes two address bytes
// - Any number of data bytes stored
// - Read starts at current pointer
// - Without word address, retained pointer used
// - Controller NACKs the last read byte
// - Address-only write presets the pointer
// - After NACK, data line released
// - Pointer wraps to 00h at end
`timescale 1ns/1ps
module twi_target
  import twi_pkg::*;
#(
  parameter bit LargeMem = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  twi_if.target     link,
  output logic      busy,
  output logic      lastWriteStored
);
  import twi_pkg::*;
  localparam int MemBytes = LargeMem ? LargeMemBytes : SmallMemBytes;
  localparam int Mw       = $clog2(MemBytes);

  typedef enum logic [5:0] {
    StIdle  = 6'h01, StAddr  = 6'h02, StAckA  = 6'h04,
    StRecv  = 6'h08, StSend  = 6'h10, StAckT  = 6'h20
  } state_t;

  logic [7:0]    clkMem [ClockRegs];
  logic [7:0]    byteMem [MemBytes];
  logic [1:0]    sclSync_q;
  logic [1:0]    sdaSync_q;
  logic          sclPrev_q;
  logic          sdaPrev_q;
  state_t        state_q;
  logic [3:0]    bitCnt_q;
  logic [7:0]    shift_q;
  logic          selMem_q;
  logic          readDir_q;
  logic [1:0]    addrBytes_q;
  logic [Mw-1:0] memPtr_q;
  logic [4:0]    clkPtr_q;
  logic          sdaOe_q;
  logic          busy_q;
  logic          stored_q;
  logic          nack_q;
  logic          sclRise;
  logic          sclFall;
  logic          startSeen;
  logic          stopSeen;
  logic          addrMatch;
  logic          matchMem;
  logic [7:0]    txByte;
  logic [Mw:0]   fData;
  logic          fValid;
  logic          fInReady;
  logic          pushData;
  logic [Mw:0]   pushWord;
  logic [7:0]    txUnused;

  assign sclRise   = sclSync_q[1] && !sclPrev_q;
  assign sclFall   = !sclSync_q[1] && sclPrev_q;
  assign startSeen = sclSync_q[1] && sclPrev_q && sdaPrev_q && !sdaSync_q[1];
  assign stopSeen  = sclSync_q[1] && sclPrev_q && !sdaPrev_q && sdaSync_q[1];
  assign matchMem  = LargeMem ? (shift_q[7:1] == MemWideAddr) : (shift_q[7:4] == MemPrefix);
  assign addrMatch = (shift_q[7:1] == ClockAddr) || matchMem;
  assign txByte    = selMem_q ? byteMem[memPtr_q] : clkMem[clkPtr_q];
  assign busy            = busy_q;
  assign lastWriteStored = stored_q;
  assign link.sdaTgtOut  = 1'b0;
  assign link.sdaTgtOe   = sdaOe_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], link.scl};
      sdaSync_q <= {sdaSync_q[0], link.sda};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= StIdle;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      selMem_q    <= 1'b0;
      readDir_q   <= 1'b0;
      addrBytes_q <= 2'h0;
      memPtr_q    <= '0;
      clkPtr_q    <= 5'h00;
      sdaOe_q     <= 1'b1;
      busy_q      <= 1'b0;
      nack_q      <= 1'b0;
      pushData    <= 1'b0;
      pushWord    <= '0;
    end else begin
      pushData <= 1'b0;
      if (startSeen) begin
        state_q  <= StAddr;
        bitCnt_q <= 4'h0;
        sdaOe_q  <= 1'b1;
        busy_q   <= 1'b1;
      end else if (stopSeen) begin
        state_q <= StIdle;
        sdaOe_q <= 1'b1;
        busy_q  <= 1'b0;
      end else begin
        case (state_q)
          StIdle: begin
            sdaOe_q <= 1'b1;
          end
          StAddr, StRecv: begin
            if (sclRise) begin
              shift_q  <= {shift_q[6:0], sdaSync_q[1]};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (state_q == StAddr) begin
                if (addrMatch) begin
                  sdaOe_q     <= 1'b0;
                  selMem_q    <= matchMem;
                  readDir_q   <= shift_q[0];
                  addrBytes_q <= 2'h0;
                  if (!LargeMem && matchMem) begin
                    memPtr_q <= Mw'({shift_q[3:1], memPtr_q[7:0]});
                  end
                  state_q <= StAckA;
                end else begin
                  state_q <= StIdle;
                end
              end else begin
                sdaOe_q <= 1'b0;
                state_q <= StAckA;
                if (addrBytes_q == 2'h2 || (addrBytes_q == 2'h1 && !(LargeMem && selMem_q))) begin
                  pushData <= 1'b1;
                  pushWord <= {selMem_q, selMem_q ? memPtr_q : Mw'(clkPtr_q)};
                  shift_q  <= shift_q;
                  if (selMem_q) begin
                    memPtr_q <= memPtr_q + 1'b1;
                  end else begin
                    clkPtr_q <= (clkPtr_q == 5'(ClockRegs - 1)) ? 5'h00 : clkPtr_q + 5'h01;
                  end
                end else if (selMem_q && LargeMem && addrBytes_q == 2'h0) begin
                  memPtr_q    <= Mw'({shift_q, memPtr_q[7:0]});
                  addrBytes_q <= 2'h1;
                end else begin
                  if (!selMem_q) begin
                    clkPtr_q <= (shift_q < 8'(ClockRegs)) ? shift_q[4:0] : 5'h00;
                  end else if (LargeMem) begin
                    memPtr_q <= Mw'({memPtr_q[Mw-1:8], shift_q});
                  end else begin
                    memPtr_q <= Mw'({memPtr_q[Mw-1:8], shift_q});
                  end
                  addrBytes_q <= 2'h2;
                end
              end
            end
          end
          StAckA: begin
            // After the ninth clock, release for a write or drive the first read bit
            if (sclFall) begin
              if (readDir_q) begin
                shift_q  <= txByte;
                sdaOe_q  <= txByte[7];
                bitCnt_q <= 4'h1;
                state_q  <= StSend;
              end else begin
                sdaOe_q <= 1'b1;
                state_q <= StRecv;
              end
            end
          end
          StSend: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sdaOe_q <= 1'b1;
                state_q <= StAckT;
                if (selMem_q) begin
                  memPtr_q <= memPtr_q + 1'b1;
                end else begin
                  clkPtr_q <= (clkPtr_q == 5'(ClockRegs - 1)) ? 5'h00 : clkPtr_q + 5'h01;
                end
              end else begin
                sdaOe_q  <= shift_q[7 - bitCnt_q[2:0]];
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          StAckT: begin
            if (sclRise) begin
              nack_q <= sdaSync_q[1];
            end else if (sclFall) begin
              if (nack_q) begin
                sdaOe_q <= 1'b1;
                state_q <= StIdle;
              end else begin
                shift_q  <= txByte;
                sdaOe_q  <= txByte[7];
                bitCnt_q <= 4'h1;
                state_q  <= StSend;
              end
            end
          end
          default: state_q <= StIdle;
        endcase
      end
    end
  end

  // Bytes outpace nothing here, but the FIFO decouples storage timing
  byte_fifo #(.Width(Mw + 9), .Depth(FifoDepth)) storeFifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inData   ({pushWord, shift_q}),
    .inValid  (pushData),
    .inReady  (fInReady),
    .outData  ({fData, txUnused}),
    .outValid (fValid),
    .outReady (1'b1)
  );

  always_ff @(posedge sys_clk) begin
    if (fValid) begin
      if (fData[Mw]) begin
        byteMem[fData[Mw-1:0]] <= txUnused;
      end else begin
        clkMem[fData[4:0]] <= txUnused;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stored_q <= 1'b0;
    end else begin
      stored_q <= fValid;
    end
  end
endmodule : twi_target

// >>> hw/twi_pkg.sv
// Purpose: Shared constants for the two-wire clock/memory target and its controller
// Assumes: 40 MHz system clock, 7-bit addressing
// Notes:   Memory option chosen by a parameter of the target
package twi_pkg;
  localparam logic [6:0] ClockAddr      = 7'h68;  // 1101000
  localparam logic [3:0] MemPrefix      = 4'ha;   // 1010 block-select family
  localparam logic [6:0] MemWideAddr    = 7'h50;  // 1010000
  localparam int         ClockRegs      = 20;     // clock register locations
  localparam int         SmallMemBytes  = 2048;
  localparam int         LargeMemBytes  = 8192;
  localparam int         SysClkNs       = 25;
  localparam int         LinkHalfNs     = 100;    // quarter period of generated link clock
  localparam int         LinkHalfCycles = (LinkHalfNs + SysClkNs - 1) / SysClkNs;
  localparam int         FifoDepth      = 16;
  typedef enum logic [1:0] {OpWrite = 2'h0, OpRead = 2'h1} op_t;
endpackage : twi_pkg

// >>> hw/twi_if.sv
// Purpose: Two-wire link between controller and target
// Assumes: Open-drain data, clock driven by controller only
// Notes:   Wire level resolved here from the active-low enables
`timescale 1ns/1ps
interface twi_if;
  logic sclOut;
  logic sclOe;
  logic sdaCtlOut;
  logic sdaCtlOe;
  logic sdaTgtOut;
  logic sdaTgtOe;
  logic scl;
  logic sda;
  assign scl = sclOe ? 1'b1 : sclOut;
  assign sda = (sdaCtlOe ? 1'b1 : sdaCtlOut) & (sdaTgtOe ? 1'b1 : sdaTgtOut);
  modport target (input scl, input sda, output sdaTgtOut, output sdaTgtOe);
  modport controller (input scl, input sda, output sclOut, output sclOe,
                      output sdaCtlOut, output sdaCtlOe);
endinterface : twi_if

// >>> hw/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Depth is a power of two
`timescale 1ns/1ps
module byte_fifo #(
  parameter int Width = 8,
  parameter int Depth = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [Width-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [Width-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int Aw = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [Aw:0]      wrPtr_q;
  logic [Aw:0]      rdPtr_q;
  logic             full;
  logic             empty;
  assign empty    = wrPtr_q == rdPtr_q;
  assign full     = (wrPtr_q[Aw] != rdPtr_q[Aw]) && (wrPtr_q[Aw-1:0] == rdPtr_q[Aw-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[Aw-1:0]];
  always_ff @(posedge sys_clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[Aw-1:0]] <= inData;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule : byte_fifo

// >>> hw/twi_controller.sv
// Purpose: Two-wire controller issuing write and read transfers
// Assumes: Generated link clock of four system cycles per quarter period
// Notes:   Requests accepted only while idle
`timescale 1ns/1ps
module twi_controller
  import twi_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  twi_if.controller       link,
  input  wire logic       reqValid,
  input  wire twi_pkg::op_t reqOp,
  input  wire logic [6:0] reqAddr,
  input  wire logic [7:0] reqData,
  input  wire logic [3:0] reqLen,
  output logic            reqReady,
  output logic [7:0]      rdData,
  output logic            rdValid,
  output logic            ackErr
);
  import twi_pkg::*;
  typedef enum logic [3:0] {CIdle = 4'h1, CStart = 4'h2, CBits = 4'h4, CStop = 4'h8} cstate_t;
  cstate_t    st_q;
  logic [2:0] div_q;
  logic       tick;
  logic [3:0] bit_q;
  logic [1:0] phase_q;
  logic [7:0] sh_q;
  logic [3:0] left_q;
  logic       rd_q;
  logic       first_q;
  logic       sclO_q;
  logic       sdaO_q;
  logic       rdy_q;
  logic [7:0] rdD_q;
  logic       rdV_q;
  logic       err_q;
  logic [7:0] dat_q;
  logic [1:0] sdaS_q;
  assign tick           = div_q == 3'(LinkHalfCycles - 1);
  assign link.sclOut    = 1'b0;
  assign link.sclOe     = sclO_q;
  assign link.sdaCtlOut = 1'b0;
  assign link.sdaCtlOe  = sdaO_q;
  assign reqReady       = rdy_q;
  assign rdData         = rdD_q;
  assign rdValid        = rdV_q;
  assign ackErr         = err_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q  <= 3'h0;
      sdaS_q <= 2'h3;
    end else begin
      div_q  <= tick ? 3'h0 : div_q + 3'h1;
      sdaS_q <= {sdaS_q[0], link.sda};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= CIdle;
      bit_q   <= 4'h0;
      phase_q <= 2'h0;
      sh_q    <= 8'h00;
      left_q  <= 4'h0;
      rd_q    <= 1'b0;
      first_q <= 1'b0;
      sclO_q  <= 1'b1;
      sdaO_q  <= 1'b1;
      rdy_q   <= 1'b1;
      rdD_q   <= 8'h00;
      rdV_q   <= 1'b0;
      err_q   <= 1'b0;
      dat_q   <= 8'h00;
    end else begin
      rdV_q <= 1'b0;
      case (st_q)
        CIdle: begin
          if (reqValid && rdy_q) begin
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
            rd_q    <= reqOp == OpRead;
            sh_q    <= {reqAddr, reqOp == OpRead};
            dat_q   <= reqData;
            left_q  <= reqLen;
            first_q <= 1'b1;
            phase_q <= 2'h0;
            st_q    <= CStart;
          end
        end
        CStart: if (tick) begin
          sdaO_q <= 1'b0;
          st_q   <= CBits;
          bit_q  <= 4'h0;
        end
        CBits: if (tick) begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0) begin
            sclO_q <= 1'b0;
          end else if (phase_q == 2'h1) begin
            if (bit_q < 4'h8) begin
              sdaO_q <= (rd_q && !first_q) ? 1'b1 : sh_q[7 - bit_q[2:0]];
            end else begin
              sdaO_q <= (rd_q && !first_q) ? (left_q <= 4'h1) : 1'b1;
            end
          end else if (phase_q == 2'h2) begin
            sclO_q <= 1'b1;
          end else begin
            phase_q <= 2'h0;
            if (bit_q < 4'h8) begin
              rdD_q <= {rdD_q[6:0], sdaS_q[1]};
              bit_q <= bit_q + 4'h1;
            end else begin
              bit_q   <= 4'h0;
              first_q <= 1'b0;
              sh_q    <= dat_q;
              if (!(rd_q && !first_q) && sdaS_q[1]) begin
                err_q <= 1'b1;
                st_q  <= CStop;
              end else if (rd_q && !first_q) begin
                // Read count covers data bytes only, never the address byte
                rdV_q  <= 1'b1;
                left_q <= left_q - 4'h1;
                if (left_q <= 4'h1) begin
                  st_q <= CStop;
                end
              end else if (!first_q) begin
                // The word byte always goes out; reqLen more bytes follow it
                left_q <= left_q - 4'h1;
                if (left_q == 4'h0) begin
                  st_q <= CStop;
                end
              end
            end
          end
        end
        CStop: if (tick) begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0) begin
            sclO_q <= 1'b0;
          end else if (phase_q == 2'h1) begin
            sdaO_q <= 1'b0;
          end else if (phase_q == 2'h2) begin
            sclO_q <= 1'b1;
          end else begin
            sdaO_q <= 1'b1;
            rdy_q  <= 1'b1;
            st_q   <= CIdle;
          end
        end
        default: st_q <= CIdle;
      endcase
    end
  end
endmodule : twi_controller

// >>> dv/twi_sva.sv
// Purpose: Protocol checks on the link between controller and small memory target
// Assumes: Link lines change only on sys_clk edges
// Notes:   Bit counter restarts on every START, ninth rise is the acknowledge slot
`timescale 1ns/1ps
module twi_sva (
  input logic sys_clk,
  input logic rst_b,
  input logic scl,
  input logic sda,
  input logic sclOe,
  input logic sdaCtlOe,
  input logic sdaTgtOe
);
  import twi_pkg::*;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic       firstByte_q;
  logic       readDir_q;
  logic       sclRise;
  logic       startSeen;
  logic       stopSeen;
  logic       addrHit;

  assign sclRise   = scl && !sclPrev_q;
  assign startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
  assign stopSeen  = scl && sclPrev_q && !sdaPrev_q && sda;
  assign addrHit   = (shift_q[7:1] == ClockAddr) || (shift_q[7:4] == MemPrefix);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
    end
  end

  // A repeated START counts one stray rise first; the START itself clears it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      firstByte_q <= 1'b1;
      readDir_q   <= 1'b0;
    end else if (startSeen) begin
      bitCnt_q    <= 4'h0;
      firstByte_q <= 1'b1;
    end else if (sclRise && bitCnt_q == 4'h8) begin
      bitCnt_q    <= 4'h0;
      firstByte_q <= 1'b0;
      if (firstByte_q) begin
        readDir_q <= shift_q[0];
      end
    end else if (sclRise) begin
      bitCnt_q <= bitCnt_q + 4'h1;
      shift_q  <= {shift_q[6:0], sda};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_scl_owner;
    $fell(scl) |-> !sclOe ##1 !scl [*7];
  endproperty
  a_scl_owner: assert property (p_scl_owner)
    else $error("link clock low phase not held by the controller");
  property p_idle_after_reset;
    !$past(rst_b) |-> scl && sda;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("link not idle after reset");
  property p_start_ctl;
    startSeen |-> !sdaCtlOe && sdaTgtOe;
  endproperty
  a_start_ctl: assert property (p_start_ctl)
    else $error("start not made by controller alone");
  property p_addr_ack;
    sclRise && bitCnt_q == 4'h8 && firstByte_q |-> sda == !addrHit;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge does not follow the match");
  property p_write_ack;
    sclRise && bitCnt_q == 4'h8 && !firstByte_q && !readDir_q |-> !sda;
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("received byte not acknowledged");
  property p_write_released;
    sclRise && bitCnt_q < 4'h8 && !firstByte_q && !readDir_q |-> sdaTgtOe;
  endproperty
  a_write_released: assert property (p_write_released)
    else $error("target drives data during a write bit");
  property p_nack_release;
    sclRise && bitCnt_q == 4'h8 && !firstByte_q && readDir_q && sda |=> sdaTgtOe [*8];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("target holds data line after not-acknowledge");
  property p_stop_quiet;
    stopSeen |-> sdaTgtOe [*6];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("target drives data line after stop");
  property p_stable_high;
    scl && sclPrev_q |-> $stable(sdaTgtOe);
  endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("target changes data while link clock high");
endmodule : twi_sva

// >>> dv/rtc_memory_i2c_target_tb.sv
// Purpose: Controller and target ends driven through their user sides
// Assumes: End 0 small memory option, end 1 large memory option
// Notes:   Write bytes repeat the word address, so stored values are predictable
`timescale 1ns/1ps
module rtc_memory_i2c_target_tb;
  import twi_pkg::*;
  logic       sys_clk;
  logic       rst_b;
  logic       reqValid [2];
  op_t        reqOp    [2];
  logic [6:0] reqAddr  [2];
  logic [7:0] reqData  [2];
  logic [3:0] reqLen   [2];
  wire  [1:0] reqReady;
  wire  [7:0] rdData   [2];
  wire  [1:0] rdValid;
  wire  [1:0] ackErr;
  wire  [1:0] busy;
  wire  [1:0] lastWriteStored;
  logic [7:0] rdQ      [2][$];
  int         wrCnt    [2];
  int         failures = 0;
  int         compares = 0;
  int         wireBits = 99;
  logic [7:0] wireSh   = 8'h00;
  logic       sclP     = 1'b1;
  logic       sdaP     = 1'b1;
  logic [6:0] badAddr  [4] = '{7'h69, 7'h48, 7'h58, 7'h2a};

  for (genvar g = 0; g < 2; g++) begin : gEnd
    twi_if link ();
    twi_controller twi_controller_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .reqValid(reqValid[g]),
      .reqOp(reqOp[g]), .reqAddr(reqAddr[g]), .reqData(reqData[g]), .reqLen(reqLen[g]),
      .reqReady(reqReady[g]), .rdData(rdData[g]), .rdValid(rdValid[g]), .ackErr(ackErr[g])
    );
    twi_target #(.LargeMem(g == 1)) twi_target_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .busy(busy[g]),
      .lastWriteStored(lastWriteStored[g])
    );
  end

  twi_sva twi_sva_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl(gEnd[0].link.scl), .sda(gEnd[0].link.sda),
    .sclOe(gEnd[0].link.sclOe), .sdaCtlOe(gEnd[0].link.sdaCtlOe),
    .sdaTgtOe(gEnd[0].link.sdaTgtOe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Sampled at the falling edge, away from the design's updates
  always @(negedge sys_clk) begin
    for (int e = 0; e < 2; e++) begin
      if (rdValid[e] === 1'b1) rdQ[e].push_back(rdData[e]);
      if (lastWriteStored[e] === 1'b1) wrCnt[e]++;
    end
    if (gEnd[0].link.scl && sclP && sdaP && !gEnd[0].link.sda) wireBits = 0;
    else if (gEnd[0].link.scl && !sclP) begin
      if (wireBits < 8) wireSh = {wireSh[6:0], gEnd[0].link.sda};
      wireBits++;
    end
    sclP = gEnd[0].link.scl;
    sdaP = gEnd[0].link.sda;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic run(input int e, input op_t op, input logic [6:0] a, input logic [7:0] d,
                     input logic [3:0] n, input logic nak);
    int t;
    rdQ[e].delete();
    wrCnt[e] = 0;
    reqValid[e] = 1'b1;
    reqOp[e] = op;
    reqAddr[e] = a;
    reqData[e] = d;
    reqLen[e] = n;
    @(negedge sys_clk);
    reqValid[e] = 1'b0;
    t = 0;
    while ((reqReady[e] !== 1'b1 || busy[e] !== 1'b0 || t < 2) && t < 4000) begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 4000) failures++;
    check({7'h00, ackErr[e]}, {7'h00, nak}); // address answer
    check(8'(wrCnt[e]), (op == OpWrite && !nak) ? 8'(n) - 8'(e) : 8'h00); // stored
    check(8'(rdQ[e].size()), (op == OpRead && !nak) ? 8'(n) : 8'h00); // read count
    if (e == 0) check(wireSh, {a, op == OpRead}); // first byte on wire
  endtask : run

  task automatic expect_all(input int e, input logic [7:0] v);
    for (int i = 0; i < rdQ[e].size(); i++) check(rdQ[e][i], v);
  endtask : expect_all

  initial begin
    repeat (80000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    for (int e = 0; e < 2; e++) begin
      reqValid[e] = 1'b0;
      reqOp[e] = OpWrite;
      reqAddr[e] = 7'h00;
      reqData[e] = 8'h00;
      reqLen[e] = 4'h0;
    end
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    check({6'h00, reqReady}, 8'h03); // idle ready
    check({6'h00, busy}, 8'h00); // not busy
    // Last clock location is ClockRegs-1; the burst wraps to 00h
    run(0, OpWrite, ClockAddr, 8'(ClockRegs - 1), 4'h3, 1'b0); // wrap
    run(0, OpWrite, ClockAddr, 8'(ClockRegs - 1), 4'h0, 1'b0); // preset
    run(0, OpRead, ClockAddr, 8'h00, 4'h2, 1'b0); // read
    expect_all(0, 8'(ClockRegs - 1)); // wrapped
    run(0, OpRead, ClockAddr, 8'h00, 4'h1, 1'b0); // retained
    expect_all(0, 8'(ClockRegs - 1)); // retained
    run(0, OpWrite, ClockAddr, 8'h05, 4'hf, 1'b0); // burst
    run(0, OpWrite, ClockAddr, 8'h05, 4'h0, 1'b0); // pointer load
    run(0, OpRead, ClockAddr, 8'h00, 4'hf, 1'b0); // burst
    expect_all(0, 8'h05); // burst
    // Block 1 overlaps block 3's low byte; a block-blind target reads back 77
    run(0, OpWrite, {MemPrefix, 3'h3}, 8'h76, 4'h2, 1'b0); // block
    run(0, OpWrite, {MemPrefix, 3'h1}, 8'h77, 4'h1, 1'b0); // block
    run(0, OpWrite, {MemPrefix, 3'h3}, 8'h77, 4'h0, 1'b0); // block
    run(0, OpRead, {MemPrefix, 3'h3}, 8'h00, 4'h1, 1'b0); // block
    expect_all(0, 8'h76); // block
    for (int b = 0; b < 8; b++) begin
      run(0, OpWrite, {MemPrefix, 3'(b)}, 8'h40, 4'h0, 1'b0); // family
    end
    foreach (badAddr[i]) run(0, OpWrite, badAddr[i], 8'h00, 4'h1, 1'b1); // refused
    run(0, OpRead, badAddr[0], 8'h00, 4'h1, 1'b1); // refused
    run(1, OpWrite, MemWideAddr, 8'h12, 4'h3, 1'b0); // two bytes
    run(1, OpWrite, MemWideAddr, 8'h13, 4'h2, 1'b0); // two bytes
    run(1, OpWrite, MemWideAddr, 8'h12, 4'h1, 1'b0); // preset
    run(1, OpRead, MemWideAddr, 8'h00, 4'h2, 1'b0); // two bytes
    expect_all(1, 8'h12); // two bytes
    run(1, OpWrite, {MemPrefix, 3'h1}, 8'h00, 4'h1, 1'b1); // single address
    // Reset mid-run: both ends idle again, pointer back at 00h, contents kept
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    check({6'h00, reqReady}, 8'h03); // idle ready
    check({6'h00, busy}, 8'h00); // not busy
    check({6'h00, ackErr}, 8'h00); // answer cleared
    run(0, OpRead, ClockAddr, 8'h00, 4'h1, 1'b0); // from 00h
    expect_all(0, 8'(ClockRegs - 1)); // from 00h
    print_verdict();
  end
endmodule : rtc_memory_i2c_target_tb
